// *** ssb_fifo.sv ***
/*
  ssb_pkg: shared constants of the serial port queue/interrupt/dma block.
  ssb_fifo: synchronous queue used for both transmit and receive data.
  assumes a single clock domain and an asynchronous active-low reset.
*/
package ssb_pkg;
  localparam int unsigned SSB_WIDTH        = 16;
  localparam int unsigned SSB_DEPTH        = 8;
  localparam int unsigned SSB_PTR_W        = 3;
  localparam int unsigned SSB_CNT_W        = 4;
  localparam logic [3:0]  SSB_TX_IRQ_LVL   = 4'h4;
  localparam logic [3:0]  SSB_RX_IRQ_LVL   = 4'h4;
  localparam logic [3:0]  SSB_DMA_BURST    = 4'h4;
  localparam logic [3:0]  SSB_BIT_LAST     = 4'hf;
  localparam logic [5:0]  SSB_TIMEOUT_BITS = 6'h20;
  localparam int unsigned SSB_CLK_MHZ      = 50;
  localparam int unsigned SSB_BIT_NS       = 160;
  localparam int unsigned SSB_BIT_CYC      = (SSB_BIT_NS * SSB_CLK_MHZ + 999) / 1000;
  localparam int unsigned SSB_IRQ_TX       = 3;
  localparam int unsigned SSB_IRQ_RX       = 2;
  localparam int unsigned SSB_IRQ_TO       = 1;
  localparam int unsigned SSB_IRQ_OR       = 0;
endpackage : ssb_pkg

`timescale 1ns/1ps
module ssb_fifo (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          nrst,
  // fill side
  input  wire logic                          push,
  input  wire logic [ssb_pkg::SSB_WIDTH-1:0] wdata,
  // drain side
  input  wire logic                          pop,
  output logic      [ssb_pkg::SSB_WIDTH-1:0] rdata,
  // state
  output logic      [ssb_pkg::SSB_CNT_W-1:0] count,
  output logic                               full,
  output logic                               empty
);
  import ssb_pkg::*;

  logic [SSB_WIDTH-1:0] mem_q [SSB_DEPTH];
  logic [SSB_PTR_W-1:0] wr_q;
  logic [SSB_PTR_W-1:0] rd_q;
  logic [SSB_CNT_W-1:0] cnt_q;
  logic                 do_push;
  logic                 do_pop;

  assign full    = (cnt_q == SSB_CNT_W'(SSB_DEPTH));
  assign empty   = (cnt_q == '0);
  assign count   = cnt_q;
  assign rdata   = mem_q[rd_q];
  assign do_pop  = pop && !empty;
  // a push into a full queue is taken only when a word leaves in the same cycle
  assign do_push = push && (!full || do_pop);

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_q[wr_q] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= wr_q + 3'h1;
      end
      if (do_pop) begin
        rd_q <= rd_q + 3'h1;
      end
      if (do_push && !do_pop) begin
        cnt_q <= cnt_q + 4'h1;
      end else if (do_pop && !do_push) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule : ssb_fifo

// *** ssb_port.sv ***
/*
  ssb_port: queue, interrupt and dma-request logic of a synchronous serial port,
  with a minimal slave shifter (clock idle low, capture on rising edge, 16-bit words).
  assumes the serial clock, frame select and data input pins are asynchronous and
  at least four system clocks per serial clock phase; all control bits are plain ports.
*/
`timescale 1ns/1ps

// Summary of operation
// - transmit queue of eight 16-bit words, same in master and slave use.
// - receive queue of eight 16-bit words, same in master and slave use.
// - four active-high sources, each maskable, ORed into one combined interrupt.
// - transmit source high while transmit queue holds four or fewer words.
// - transmit source also high while the port is disabled.
// - receive source high while receive queue holds four or more words.
// - timeout set when receive queue non-empty and link idle 32 bit periods.
// - timeout cleared by itself when a transfer starts with receive space free.
// - transfer into a full receive queue keeps timeout and raises overrun.
// - ninth word into full queue raises overrun; it and later words dropped.
// - a read during the ninth word lets it be stored without overrun.
// - writing one to timeout or overrun clear bit clears that flag.
// - raw and masked status flag exposed for each of the four sources.
// - separate transmit and receive dma enables gate the request outputs.
// - receive burst request when receive queue holds four filled words.
// - transmit burst request when transmit queue has four empty places.
// - a request holds until its clear input; may rise again after clear drops.
// - all requests low while port disabled or dma enable cleared.
// - no burst request for a leftover of three or fewer words.
// - transfer starts on the master's frame select while enabled; queued data only raises tx_start_pending.
module ssb_port #(
  parameter int unsigned BIT_CYC = ssb_pkg::SSB_BIT_CYC
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          nrst,
  // control bits
  input  wire logic                          port_enable_bit,
  input  wire logic                          tx_dma_enable_bit,
  input  wire logic                          rx_dma_enable_bit,
  input  wire logic [3:0]                    irq_mask,
  input  wire logic                          timeout_clear_bit,
  input  wire logic                          overrun_clear_bit,
  // transmit queue write
  input  wire logic                          tx_wr_valid,
  input  wire logic [ssb_pkg::SSB_WIDTH-1:0] tx_wr_data,
  output logic                               tx_wr_ready,
  // receive queue read
  output logic                               rx_rd_valid,
  output logic      [ssb_pkg::SSB_WIDTH-1:0] rx_rd_data,
  input  wire logic                          rx_rd_ready,
  // status
  output logic      [3:0]                    irq_raw,
  output logic      [3:0]                    irq_masked,
  output logic                               combined_port_interrupt,
  output logic                               tx_start_pending,
  // dma handshake
  output logic                               tx_dma_burst_request,
  output logic                               rx_dma_burst_request,
  input  wire logic                          tx_dma_clear,
  input  wire logic                          rx_dma_clear,
  // link pins
  input  wire logic                          serial_clock_pin,
  input  wire logic                          frame_select_pin_n,
  input  wire logic                          data_in_pin,
  output logic                               data_out_pin,
  output logic                               data_out_oe_n
);
  import ssb_pkg::*;

  typedef enum logic [2:0] {
    SSB_IDLE  = 3'b001,
    SSB_SHIFT = 3'b010,
    SSB_WAIT  = 3'b100
  } ssb_state_t;

  function automatic logic ssb_at_least(input logic [SSB_CNT_W-1:0] cnt, input logic [3:0] lvl);
    ssb_at_least = (cnt >= lvl);
  endfunction : ssb_at_least

  // pin synchronisers
  logic [1:0] sck_sync_q;
  logic [1:0] fss_sync_q;
  logic [1:0] din_sync_q;
  logic       sck_prev_q;
  logic       fss_prev_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_sync_q <= 2'h0;
      fss_sync_q <= 2'h3;
      din_sync_q <= 2'h0;
      sck_prev_q <= 1'b0;
      fss_prev_q <= 1'b1;
    end else begin
      sck_sync_q <= {sck_sync_q[0], serial_clock_pin};
      fss_sync_q <= {fss_sync_q[0], frame_select_pin_n};
      din_sync_q <= {din_sync_q[0], data_in_pin};
      sck_prev_q <= sck_sync_q[1];
      fss_prev_q <= fss_sync_q[1];
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic fss_fall;
  assign sck_rise = sck_sync_q[1] && !sck_prev_q;
  assign sck_fall = !sck_sync_q[1] && sck_prev_q;
  assign fss_fall = !fss_sync_q[1] && fss_prev_q;

  // queues
  logic [SSB_WIDTH-1:0] tx_head;
  logic [SSB_CNT_W-1:0] tx_count;
  logic                 tx_full;
  logic                 tx_empty;
  logic                 tx_pop;
  logic [SSB_CNT_W-1:0] rx_count;
  logic                 rx_full;
  logic                 rx_empty;
  logic                 rx_push;
  logic                 rx_pop;
  logic [SSB_WIDTH-1:0] rx_sh_q;
  logic [SSB_WIDTH-1:0] rx_word;

  assign tx_wr_ready = !tx_full;
  assign rx_rd_valid = !rx_empty;
  assign rx_pop      = rx_rd_valid && rx_rd_ready;

  ssb_fifo u_tx_fifo (
    .clk   (clk),
    .nrst  (nrst),
    .push  (tx_wr_valid && tx_wr_ready),
    .wdata (tx_wr_data),
    .pop   (tx_pop),
    .rdata (tx_head),
    .count (tx_count),
    .full  (tx_full),
    .empty (tx_empty)
  );

  ssb_fifo u_rx_fifo (
    .clk   (clk),
    .nrst  (nrst),
    .push  (rx_push),
    .wdata (rx_word),
    .pop   (rx_pop),
    .rdata (rx_rd_data),
    .count (rx_count),
    .full  (rx_full),
    .empty (rx_empty)
  );

  // link sequencer
  ssb_state_t           state_q;
  logic [3:0]           bit_q;
  logic [SSB_WIDTH-1:0] tx_sh_q;
  logic                 start;
  logic                 frame_done;
  logic                 ovr_q;
  logic                 tout_q;

  // a slave cannot clock itself; the start is the master's select alone, waiting data only raises tx_start_pending
  assign tx_start_pending = port_enable_bit && !tx_empty;
  assign start            = (state_q == SSB_IDLE) && port_enable_bit && fss_fall;
  assign tx_pop           = start && !tx_empty;
  assign frame_done       = (state_q == SSB_SHIFT) && sck_rise && (bit_q == SSB_BIT_LAST);
  assign rx_word          = {rx_sh_q[SSB_WIDTH-2:0], din_sync_q[1]};
  // a word read out during reception frees the place for the ninth word
  assign rx_push          = frame_done && !ovr_q && (!rx_full || rx_pop);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= SSB_IDLE;
    end else begin
      unique case (state_q)
        SSB_IDLE: begin
          if (start) begin
            state_q <= SSB_SHIFT;
          end
        end
        SSB_SHIFT: begin
          if (fss_sync_q[1] || !port_enable_bit) begin
            state_q <= SSB_IDLE;
          end else if (frame_done) begin
            state_q <= SSB_WAIT;
          end
        end
        SSB_WAIT: begin
          if (fss_sync_q[1] || !port_enable_bit) begin
            state_q <= SSB_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bit_q   <= 4'h0;
      tx_sh_q <= '0;
      rx_sh_q <= '0;
    end else if (start) begin
      bit_q   <= 4'h0;
      // an empty queue sends zeros rather than stale data
      tx_sh_q <= tx_empty ? '0 : tx_head;
    end else if (state_q == SSB_SHIFT) begin
      if (sck_rise) begin
        rx_sh_q <= rx_word;
        bit_q   <= bit_q + 4'h1;
      end
      if (sck_fall) begin
        tx_sh_q <= {tx_sh_q[SSB_WIDTH-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_out_pin  <= 1'b0;
      data_out_oe_n <= 1'b1;
    end else begin
      data_out_pin  <= tx_sh_q[SSB_WIDTH-1];
      data_out_oe_n <= (state_q == SSB_IDLE);
    end
  end

  // bit-period tick and idle counter
  logic [7:0] div_q;
  logic       bit_tick;
  logic [5:0] idle_q;
  logic       link_idle;
  logic       tout_set;
  logic       ovr_set;

  assign bit_tick  = (div_q == 8'(BIT_CYC - 1));
  assign link_idle = (state_q == SSB_IDLE) && fss_sync_q[1];
  assign tout_set  = link_idle && !rx_empty && bit_tick && (idle_q == SSB_TIMEOUT_BITS - 6'h1);
  // set does not look at the flag, so a loss in the clearing cycle still wins over the clear
  assign ovr_set   = frame_done && rx_full && !rx_pop;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= 8'h0;
    end else begin
      div_q <= bit_tick ? 8'h0 : div_q + 8'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idle_q <= 6'h0;
    end else if (!link_idle || rx_empty || tout_set) begin
      idle_q <= 6'h0;
    end else if (bit_tick) begin
      idle_q <= idle_q + 6'h1;
    end
  end

  // sticky flags; a new event beats a clear in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tout_q <= 1'b0;
    end else if (tout_set) begin
      tout_q <= 1'b1;
    end else if (timeout_clear_bit || (start && !rx_full)) begin
      tout_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ovr_q <= 1'b0;
    end else if (ovr_set) begin
      ovr_q <= 1'b1;
    end else if (overrun_clear_bit) begin
      ovr_q <= 1'b0;
    end
  end

  // interrupt sources
  assign irq_raw[SSB_IRQ_TX]     = !port_enable_bit || !ssb_at_least(tx_count, SSB_TX_IRQ_LVL + 4'h1);
  assign irq_raw[SSB_IRQ_RX]     = ssb_at_least(rx_count, SSB_RX_IRQ_LVL);
  assign irq_raw[SSB_IRQ_TO]     = tout_q;
  assign irq_raw[SSB_IRQ_OR]     = ovr_q;
  assign irq_masked              = irq_raw & irq_mask;
  assign combined_port_interrupt = |irq_masked;

  // dma requests; a partial burst never reaches the watermark so is never requested
  logic tx_cond;
  logic rx_cond;
  assign rx_cond = ssb_at_least(rx_count, SSB_DMA_BURST);
  assign tx_cond = ssb_at_least(4'(SSB_DEPTH) - tx_count, SSB_DMA_BURST);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_dma_burst_request <= 1'b0;
    end else if (!port_enable_bit || !rx_dma_enable_bit || rx_dma_clear) begin
      rx_dma_burst_request <= 1'b0;
    end else if (rx_cond) begin
      rx_dma_burst_request <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_dma_burst_request <= 1'b0;
    end else if (!port_enable_bit || !tx_dma_enable_bit || tx_dma_clear) begin
      tx_dma_burst_request <= 1'b0;
    end else if (tx_cond) begin
      tx_dma_burst_request <= 1'b1;
    end
  end

  // checks
  a_irq_combine: assert property (@(posedge clk) disable iff (!nrst)
    combined_port_interrupt == |(irq_raw & irq_mask)) else $error("combined interrupt mismatch");
  a_tx_irq_level: assert property (@(posedge clk) disable iff (!nrst)
    (port_enable_bit && tx_count <= 4'h4) |-> irq_raw[SSB_IRQ_TX]) else $error("tx source missing");
  a_tx_irq_off: assert property (@(posedge clk) disable iff (!nrst)
    (!port_enable_bit) |-> irq_raw[SSB_IRQ_TX]) else $error("tx source low while disabled");
  a_rx_irq_level: assert property (@(posedge clk) disable iff (!nrst)
    irq_raw[SSB_IRQ_RX] == (rx_count >= 4'h4)) else $error("rx source wrong");
  a_timeout_set: assert property (@(posedge clk) disable iff (!nrst)
    (link_idle && !rx_empty && bit_tick && idle_q == 6'h1f) |=> tout_q) else $error("timeout not set");
  a_timeout_auto: assert property (@(posedge clk) disable iff (!nrst)
    (start && !rx_full) |=> !tout_q) else $error("timeout not cleared at start");
  a_overrun_set: assert property (@(posedge clk) disable iff (!nrst)
    (frame_done && rx_full && !rx_pop) |=> ovr_q) else $error("overrun not raised");
  a_overrun_drop: assert property (@(posedge clk) disable iff (!nrst)
    (frame_done && ovr_q) |-> !rx_push) else $error("word stored during overrun");
  a_ninth_kept: assert property (@(posedge clk) disable iff (!nrst)
    (frame_done && !ovr_q && rx_full && rx_pop) |=> (!ovr_q && rx_full)) else $error("ninth word lost");
  a_overrun_clr: assert property (@(posedge clk) disable iff (!nrst)
    (overrun_clear_bit && !ovr_set) |=> !ovr_q) else $error("overrun clear ignored");
  a_dma_hold: assert property (@(posedge clk) disable iff (!nrst)
    (rx_dma_burst_request && port_enable_bit && rx_dma_enable_bit && !rx_dma_clear)
      |=> rx_dma_burst_request) else $error("rx request dropped early");
  a_dma_off: assert property (@(posedge clk) disable iff (!nrst)
    (!port_enable_bit) |=> (!tx_dma_burst_request && !rx_dma_burst_request)) else $error("request while off");
  a_rx_dma_rise: assert property (@(posedge clk) disable iff (!nrst)
    $rose(rx_dma_burst_request) |-> $past(rx_count) >= 4'h4) else $error("rx request below watermark");
  a_tx_dma_rise: assert property (@(posedge clk) disable iff (!nrst)
    $rose(tx_dma_burst_request) |-> $past(tx_count) <= 4'h4) else $error("tx request below watermark");
endmodule : ssb_port

// *** ssb_link_model.sv ***
/*
  ssb_link_model: behavioural master standing on the serial link of the port.
  assumes the port's slave pins: clock idle low, data captured on rising edges, 16-bit words.
*/
`timescale 1ns/1ps
module ssb_link_model #(
  parameter int HALF_NS = 80
) (
  // link pins toward the port
  output logic      sck,
  output logic      fss_n,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sck   = 1'b0;
    fss_n = 1'b1;
    mosi  = 1'b0;
  end

  // one word each way, msb first; the clock stands still outside the frame
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    fss_n = 1'b0;
    mosi  = w[15];
    #(2*HALF_NS);
    for (int i = 15; i >= 0; i--) begin
      sck = 1'b1;
      // late sample: the port's output lags its pins by a few system clocks
      #(HALF_NS-5);
      r[i] = miso;
      #5;
      sck = 1'b0;
      if (i > 0) mosi = w[i-1];
      #HALF_NS;
    end
    fss_n = 1'b1;
    // a released line must not keep showing the last bit
    mosi = ~mosi;
  endtask : xfer
endmodule : ssb_link_model

// *** ssb_port_test.sv ***
/*
  ssb_port_test: self-checking bench of the port's queues, interrupt sources and dma requests.
  assumes ssb_link_model as link master; bit tick shortened to 4 clocks.
*/
`timescale 1ns/1ps
module ssb_port_test;
  import ssb_pkg::*;
  localparam int BITC = 4;
  logic clk, nrst, en, txde, rxde, toc, orc, txv, txr, rxv, rxr, txreq, rxreq, txclr, rxclr;
  logic sck, fss_n, din, dout, oe_n, comb, txpend;
  logic [3:0]  mask, raw, msk;
  logic [15:0] txd, rxd, got;
  logic [15:0] exp_rx[$];
  int n_errors, num_checks, cycles;

  ssb_port #(.BIT_CYC(BITC)) dut (.clk(clk), .nrst(nrst), .port_enable_bit(en), .tx_dma_enable_bit(txde),
    .rx_dma_enable_bit(rxde), .irq_mask(mask), .timeout_clear_bit(toc), .overrun_clear_bit(orc),
    .tx_wr_valid(txv), .tx_wr_data(txd), .tx_wr_ready(txr), .rx_rd_valid(rxv), .rx_rd_data(rxd),
    .rx_rd_ready(rxr), .irq_raw(raw), .irq_masked(msk), .combined_port_interrupt(comb),
    .tx_start_pending(txpend), .tx_dma_burst_request(txreq), .rx_dma_burst_request(rxreq),
    .tx_dma_clear(txclr), .rx_dma_clear(rxclr), .serial_clock_pin(sck), .frame_select_pin_n(fss_n),
    .data_in_pin(din), .data_out_pin(dout), .data_out_oe_n(oe_n));
  ssb_link_model link (.sck(sck), .fss_n(fss_n), .mosi(din), .miso(dout));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", name, e, g);
      n_errors++;
    end
  endtask : chk

  task automatic frame(input logic [15:0] w, input bit keep);
    link.xfer(w, got);
    if (keep) exp_rx.push_back(w);
    cyc(4);
  endtask : frame

  task automatic drain;
    rxr = 1'b1;
    while (rxv === 1'b1 && exp_rx.size() > 0) begin
      chk("rx_rd_data", exp_rx.pop_front(), rxd);
      cyc(1);
    end
    rxr = 1'b0;
    chk("rx_left", 16'h0000, {15'h0000, rxv});
  endtask : drain

  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  initial begin
    {en, txde, rxde, toc, orc, txv, rxr, txclr, rxclr} = '0;
    mask = 4'h0;
    txd  = 16'h0000;
    nrst = 1'b0;
    cyc(5);
    nrst = 1'b1;
    cyc(3);
    chk("raw_reset", 16'h0008, {12'h000, raw});
    chk("oe_reset", 16'h0001, {15'h0000, oe_n});
    txde = 1'b1;
    txv  = 1'b1;
    for (int i = 0; i < 8; i++) begin
      txd = 16'ha5c0 + 16'(i);
      cyc(1);
    end
    txv = 1'b0;
    cyc(1);
    chk("tx_full_ready", 16'h0000, {15'h0000, txr});
    chk("tx_src_off", 16'h0001, {15'h0000, raw[SSB_IRQ_TX]});
    chk("txreq_off", 16'h0000, {15'h0000, txreq});
    en = 1'b1;
    cyc(2);
    chk("tx_src_full", 16'h0000, {15'h0000, raw[SSB_IRQ_TX]});
    chk("tx_pend", 16'h0001, {15'h0000, txpend});
    rxde = 1'b1;
    for (int i = 0; i < 4; i++) begin
      frame(16'h3c00 + 16'(i), 1'b1);
      chk("tx_word", 16'ha5c0 + 16'(i), got);
      chk("rx_src", 16'(i >= 3), {15'h0000, raw[SSB_IRQ_RX]});
      chk("tx_src", 16'(i >= 3), {15'h0000, raw[SSB_IRQ_TX]});
      chk("rxreq", 16'(i >= 3), {15'h0000, rxreq});
      chk("txreq", 16'(i >= 3), {15'h0000, txreq});
    end
    rxclr = 1'b1;
    cyc(3);
    chk("rxreq_clr", 16'h0000, {15'h0000, rxreq});
    rxclr = 1'b0;
    cyc(2);
    chk("rxreq_again", 16'h0001, {15'h0000, rxreq});
    rxde = 1'b0;
    txde = 1'b0;
    cyc(2);
    chk("dma_off", 16'h0000, {14'h0000, rxreq, txreq});
    cyc(70);
    chk("to_early", 16'h0000, {15'h0000, raw[SSB_IRQ_TO]});
    cyc(70);
    chk("to_set", 16'h0001, {15'h0000, raw[SSB_IRQ_TO]});
    for (int m = 0; m < 16; m++) begin
      mask = 4'(m);
      cyc(1);
      chk("masked", {12'h000, 4'he & 4'(m)}, {12'h000, msk});
      chk("combined", 16'((4'he & 4'(m)) != 4'h0), {15'h0000, comb});
    end
    frame(16'h3c04, 1'b1);
    chk("to_auto_clr", 16'h0000, {15'h0000, raw[SSB_IRQ_TO]});
    cyc(150);
    chk("to_sticky", 16'h0001, {15'h0000, raw[SSB_IRQ_TO]});
    toc = 1'b1;
    cyc(1);
    toc = 1'b0;
    cyc(1);
    chk("to_clr", 16'h0000, {15'h0000, raw[SSB_IRQ_TO]});
    for (int i = 5; i < 8; i++) frame(16'h3c00 + 16'(i), 1'b1);
    cyc(150);
    frame(16'h3c08, 1'b0);
    chk("overrun", 16'h0001, {15'h0000, raw[SSB_IRQ_OR]});
    chk("to_kept", 16'h0001, {15'h0000, raw[SSB_IRQ_TO]});
    cyc(20);
    chk("or_sticky", 16'h0001, {15'h0000, raw[SSB_IRQ_OR]});
    rxr = 1'b1;
    chk("rx_head", exp_rx.pop_front(), rxd);
    cyc(1);
    rxr = 1'b0;
    // room in the queue now, yet the word must still be dropped while the flag stands
    frame(16'h3c09, 1'b0);
    chk("or_held", 16'h0001, {15'h0000, raw[SSB_IRQ_OR]});
    orc = 1'b1;
    cyc(1);
    orc = 1'b0;
    cyc(1);
    chk("or_clr", 16'h0000, {15'h0000, raw[SSB_IRQ_OR]});
    drain();
    for (int i = 0; i < 8; i++) frame(16'h5a00 + 16'(i), 1'b1);
    fork
      frame(16'h5a08, 1'b1);
      begin
        // the last rising link clock edge reaches the sequencer 130 clocks in: the pop lands in the cycle the word does
        cyc(130);
        rxr = 1'b1;
        chk("mid_pop", exp_rx.pop_front(), rxd);
        chk("oe_drive", 16'h0000, {15'h0000, oe_n});
        cyc(1);
        rxr = 1'b0;
      end
    join
    chk("no_overrun", 16'h0000, {15'h0000, raw[SSB_IRQ_OR]});
    drain();
    end_sim();
  end
endmodule : ssb_port_test
